/* File: ifpm_defs.svh */
`ifndef IFPM_DEFS_SVH
`define IFPM_DEFS_SVH
// register offsets on the plain register port
`define IFPM_REG_CFG 8'h00
`define IFPM_REG_STAT 8'h04
// configuration register bit positions
`define IFPM_CFG_NC8W 0
`define IFPM_CFG_NCPF 1
`define IFPM_CFG_CPF 2
`define IFPM_CFG_PIPE 3
`define IFPM_CFG_MSB 3
// status register bit positions
`define IFPM_ST_REQ 0
`define IFPM_ST_CNT_LSB 1
`define IFPM_ST_CNT_MSB 2
`define IFPM_ST_PIPE 3
`define IFPM_ST_BUSY 4
`define IFPM_ST_ERR 5
`define IFPM_ST_SINT 6
// line transfer size codes
`define IFPM_SIZE_4W 2'h1
`define IFPM_SIZE_8W 2'h2
// line and page geometry in word addresses (page is 1 KB = 256 words)
`define IFPM_LINE_MASK 30'h3FFFFFF8
`define IFPM_LINE_STEP 30'h00000008
`define IFPM_PAGE_LSB 8
// data beats per line: 4 words or 8 words, 64-bit or 32-bit slave
`define IFPM_BEATS_4W_64 4'h2
`define IFPM_BEATS_4W_32 4'h4
`define IFPM_BEATS_8W_64 4'h4
`define IFPM_BEATS_8W_32 4'h8
`endif

/* File: ifpm_pkg.sv */
package ifpm_pkg;
  // request side of the fetch port
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_ABORT = 2'b10
  } ifpm_st_type;

  // whole state of the fetch master
  typedef struct packed {
    ifpm_st_type st;
    logic req;
    logic abort;
    logic is_pf;
    logic [29:0] addr;
    logic [1:0] size;
    logic cach;
    logic uattr;
    logic [1:0] prio;
    logic [1:0] cnt;
    logic head;
    logic [1:0][3:0] beats;
    logic [1:0] disc;
    logic armed;
    logic redir;
    logic [29:0] pf_base;
    logic [3:0] cfg;
    logic err;
    logic sint_flag;
    logic [31:0] rdata;
    logic taken;
    logic [63:0] data;
    logic dvalid;
    logic [2:0] widx;
    logic derr;
    logic sint;
  } ifpm_state_type;
endpackage : ifpm_pkg

/* File: ifpm_qual_if.sv */
`timescale 1ns/1ps
// carries the prefetch question and its answer between master and qualifier
interface ifpm_qual_if;
  logic armed;
  logic slave_pipe;
  logic pipelined_busy;
  logic redirected;
  logic nc8w;
  logic ncpf;
  logic cpf;
  logic cacheable;
  logic [29:0] cur_addr;
  logic in_cache;
  logic in_fill;
  logic from_ocm;
  logic virt_mode;
  logic guarded;
  logic allow;
  logic guard_fault;
  logic [29:0] pf_addr;
  modport ctrl (output armed, slave_pipe, pipelined_busy, redirected, nc8w, ncpf, cpf,
    cacheable, cur_addr, in_cache, in_fill, from_ocm, virt_mode, guarded,
    input allow, guard_fault, pf_addr);
  modport qual (input armed, slave_pipe, pipelined_busy, redirected, nc8w, ncpf, cpf,
    cacheable, cur_addr, in_cache, in_fill, from_ocm, virt_mode, guarded,
    output allow, guard_fault, pf_addr);
endinterface : ifpm_qual_if

/* File: ifpm_prefetch_qual.sv */
`timescale 1ns/1ps
`include "ifpm_defs.svh"
// decides whether the next sequential line may be address-pipelined
module ifpm_prefetch_qual
(
  ifpm_qual_if.qual q
);
  logic same_page; // next line stays in the current 1 KB page
  logic enabled; // prefetch enable for this cacheability
  logic absent; // instructions not already on hand
  logic base_ok; // every condition but the guard check

  // purely combinational; the master registers the outcome
  always_comb
  begin
    q.pf_addr = 30'((q.cur_addr & `IFPM_LINE_MASK) + `IFPM_LINE_STEP); // R1
    same_page = q.pf_addr[29:`IFPM_PAGE_LSB] == q.cur_addr[29:`IFPM_PAGE_LSB]; // R5
    enabled = q.cacheable ? q.cpf : q.ncpf; // R7 R8
    // cached copies only matter for a cacheable line
    absent = !q.in_fill && !q.from_ocm && (!q.cacheable || !q.in_cache); // R11 R12
    base_ok = q.armed && q.slave_pipe && !q.pipelined_busy && !q.redirected // R4 R9 R10
      && q.nc8w && enabled && same_page && absent; // R6
    // virtual-mode guarded target: trap, never reach the bus
    q.guard_fault = base_ok && q.virt_mode && q.guarded; // R14
    q.allow = base_ok && !(q.virt_mode && q.guarded); // R14
  end
endmodule : ifpm_prefetch_qual

/* File: ifpm_fetch_master.sv */
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ifpm_defs.svh"
// Summary of operation
// R1: prefetch asks for next sequential eight-word line
// R2: at most one prefetch overlaps the prior fetch
// R3: prefetch goes out two cycles after acknowledge
// R4: no pipelining unless slave supports it
// R5: prefetch must stay inside current 1 KB page
// R6: four-word non-cacheable lines forbid any pipelining
// R7: non-cacheable prefetch needs its enable set
// R8: cacheable prefetch needs its enable set
// R9: no new pipelining while already pipelined
// R10: branch or interrupt cancels pending pipelined prefetch
// R11: non-cacheable prefetch only if not already fetched
// R12: cacheable prefetch only if absent everywhere
// R13: no guarded-storage indication on fetch port
// R14: virtual-mode guarded prefetch traps, never issued
// R15: thirty-bit word address, low bits implied zero
// R16: two-bit size selects four or eight words
// R17: each request carries priority and attributes
// R18: abort withdraws an unacknowledged request
// R19: slave acknowledges address and reports width
// R20: slave returns instructions with read acknowledge
// R21: slave tags each beat with word index
// R22: slave reports busy and error, unused zero
// R23: size 01 is four words, 10 eight
// R24: request drops after acknowledge, low one cycle
// R25: third request two cycles after first completes
// R26: aborted request drops next cycle, stays low
module ifpm_fetch_master
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic core_fetch_req,
  input wire logic [29:0] core_fetch_addr,
  input wire logic core_fetch_cacheable,
  input wire logic core_fetch_user_attr,
  input wire logic [1:0] core_fetch_priority,
  input wire logic core_redirect,
  input wire logic core_virt_mode,
  input wire logic core_pf_guarded,
  input wire logic core_pf_in_cache,
  input wire logic core_pf_in_fill,
  input wire logic core_pf_from_ocm,
  output logic core_fetch_taken,
  output logic [63:0] core_data,
  output logic core_data_valid,
  output logic [2:0] core_word_index,
  output logic core_data_error,
  output logic core_storage_int,
  output logic fetch_req_out,
  output logic [29:0] fetch_addr_out,
  output logic [1:0] fetch_size_out,
  output logic fetch_cacheable_out,
  output logic fetch_user_attr_out,
  output logic [1:0] fetch_priority_out,
  output logic fetch_abort_out,
  input wire logic slave_addr_ack_in,
  input wire logic slave_width_in,
  input wire logic slave_rdata_ack_in,
  input wire logic [63:0] slave_rdata_in,
  input wire logic [2:0] slave_word_index_in,
  input wire logic slave_busy_in,
  input wire logic slave_error_in
);
  ifpm_pkg::ifpm_state_type r; // registered state
  ifpm_pkg::ifpm_state_type next_r; // its next value
  ifpm_qual_if q (); // link to the prefetch qualifier
  logic tail; // slot that the next acknowledged request fills
  logic acked; // request taken by the slave this cycle
  logic done; // head slot finished its last beat
  logic pipelined; // two requests overlap on the bus
  logic [31:0] stat; // status word as software sees it

  // beats a line needs: a 32-bit slave doubles the count
  function automatic logic [3:0] beats_of(input logic [1:0] size, input logic wide);
    if (size == `IFPM_SIZE_8W)
      beats_of = wide ? `IFPM_BEATS_8W_64 : `IFPM_BEATS_8W_32;
    else
      beats_of = wide ? `IFPM_BEATS_4W_64 : `IFPM_BEATS_4W_32;
  endfunction : beats_of

  ifpm_prefetch_qual u_qual
  (
    .q(q.qual)
  );

  // questions put to the qualifier, from registered state and the core's redirect and prefetch inputs
  always_comb
  begin
    pipelined = (r.cnt == 2'h2) || (r.cnt == 2'h1 && r.req);
    q.armed = r.armed;
    q.slave_pipe = r.cfg[`IFPM_CFG_PIPE];
    q.pipelined_busy = pipelined;
    // a redirect this very cycle already counts
    q.redirected = r.redir || core_redirect;
    q.nc8w = r.cfg[`IFPM_CFG_NC8W];
    q.ncpf = r.cfg[`IFPM_CFG_NCPF];
    q.cpf = r.cfg[`IFPM_CFG_CPF];
    q.cacheable = r.cach;
    q.cur_addr = r.pf_base;
    q.in_cache = core_pf_in_cache;
    q.in_fill = core_pf_in_fill;
    q.from_ocm = core_pf_from_ocm;
    q.virt_mode = core_virt_mode;
    q.guarded = core_pf_guarded;
  end

  // status word; no guarded-storage bit exists anywhere on the port
  always_comb
  begin
    stat = 32'h00000000; // R13
    stat[`IFPM_ST_REQ] = r.req;
    stat[`IFPM_ST_CNT_MSB:`IFPM_ST_CNT_LSB] = r.cnt;
    stat[`IFPM_ST_PIPE] = pipelined;
    stat[`IFPM_ST_BUSY] = slave_busy_in; // R22
    stat[`IFPM_ST_ERR] = r.err;
    stat[`IFPM_ST_SINT] = r.sint_flag;
  end

  // next state: registers, data return, request sequencing
  always_comb
  begin
    next_r = r;
    next_r.taken = 1'b0;
    next_r.dvalid = 1'b0;
    next_r.derr = 1'b0;
    next_r.sint = 1'b0;
    next_r.rdata = 32'h00000000;
    tail = r.head ^ r.cnt[0];
    acked = r.req && slave_addr_ack_in;
    done = 1'b0;
    // register writes; sticky flags clear first so a set wins below
    if (reg_wr && reg_addr == `IFPM_REG_CFG)
      next_r.cfg = reg_wdata[`IFPM_CFG_MSB:0];
    if (reg_wr && reg_addr == `IFPM_REG_STAT)
    begin
      if (reg_wdata[`IFPM_ST_ERR])
        next_r.err = 1'b0;
      if (reg_wdata[`IFPM_ST_SINT])
        next_r.sint_flag = 1'b0;
    end
    // read data stand one cycle only; unmapped reads return zero
    if (reg_rd && reg_addr == `IFPM_REG_CFG)
      next_r.rdata = {28'h0000000, r.cfg};
    else if (reg_rd && reg_addr == `IFPM_REG_STAT)
      next_r.rdata = stat;
    // redirect: no more overlap, drop data of acknowledged lines
    if (core_redirect)
    begin
      next_r.redir = 1'b1; // R10
      next_r.armed = 1'b0; // R10
      next_r.disc = 2'h3;
    end
    // read data beats belong to the oldest slot, in order
    if (slave_rdata_ack_in && r.cnt != 2'h0)
    begin
      next_r.data = slave_rdata_in; // R20
      next_r.widx = slave_word_index_in; // R21
      next_r.dvalid = !r.disc[r.head] && !core_redirect;
      next_r.beats[r.head] = 4'(r.beats[r.head] - 4'h1);
      if (r.beats[r.head] == 4'h1)
      begin
        done = 1'b1; // R25
        next_r.head = ~r.head;
        next_r.armed = 1'b0; // overlap window closed
      end
    end
    if (slave_error_in)
    begin
      next_r.derr = 1'b1; // R22
      next_r.err = 1'b1;
    end
    case (r.st)
      ifpm_pkg::ST_IDLE:
      begin
        // the idle cycle itself is the gap after acknowledge or abort
        if (q.allow)
        begin
          next_r.st = ifpm_pkg::ST_REQ; // R2 R3
          next_r.req = 1'b1;
          next_r.is_pf = 1'b1;
          next_r.addr = q.pf_addr; // R1 R15
          next_r.size = `IFPM_SIZE_8W; // R1
          next_r.armed = 1'b0; // R9
        end
        else if (q.guard_fault)
        begin
          next_r.sint = 1'b1; // R14
          next_r.sint_flag = 1'b1;
          next_r.armed = 1'b0;
        end
        // demand fetch waits for an empty bus, so a third never crowds in
        else if (core_fetch_req && r.cnt == 2'h0)
        begin
          next_r.st = ifpm_pkg::ST_REQ; // R25
          next_r.req = 1'b1;
          next_r.is_pf = 1'b0;
          next_r.addr = core_fetch_addr; // R15
          next_r.cach = core_fetch_cacheable; // R17
          next_r.uattr = core_fetch_user_attr; // R17
          next_r.prio = core_fetch_priority; // R17
          // cacheable lines are always eight words
          next_r.size = (core_fetch_cacheable || r.cfg[`IFPM_CFG_NC8W]) ?
            `IFPM_SIZE_8W : `IFPM_SIZE_4W; // R16 R23
          next_r.redir = 1'b0;
          next_r.taken = 1'b1;
        end
      end
      ifpm_pkg::ST_REQ:
      begin
        if (acked)
        begin
          next_r.st = ifpm_pkg::ST_IDLE; // R24
          next_r.req = 1'b0;
          next_r.beats[tail] = beats_of(r.size, slave_width_in); // R19
          next_r.disc[tail] = core_redirect;
          // only an undisturbed eight-word demand fetch opens a prefetch
          if (!r.is_pf && r.size == `IFPM_SIZE_8W && !r.redir && !core_redirect)
          begin
            next_r.armed = 1'b1; // R1
            next_r.pf_base = r.addr;
          end
        end
        else if (core_redirect)
        begin
          next_r.st = ifpm_pkg::ST_ABORT; // R18
          next_r.abort = 1'b1;
        end
      end
      ifpm_pkg::ST_ABORT:
      begin
        // a slave may still take it in the abort cycle: keep count, drop data
        next_r.st = ifpm_pkg::ST_IDLE; // R26
        next_r.req = 1'b0;
        next_r.abort = 1'b0;
        if (acked)
        begin
          next_r.beats[tail] = beats_of(r.size, slave_width_in);
          next_r.disc[tail] = 1'b1;
        end
      end
      default:
      begin
        next_r.st = ifpm_pkg::ST_IDLE;
        next_r.req = 1'b0;
        next_r.abort = 1'b0;
      end
    endcase
    next_r.cnt = 2'(r.cnt + {1'b0, acked} - {1'b0, done}); // R2
  end

  // one register for the whole state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  // every output is a field of the state register
  assign reg_rdata = r.rdata;
  assign core_fetch_taken = r.taken;
  assign core_data = r.data;
  assign core_data_valid = r.dvalid;
  assign core_word_index = r.widx;
  assign core_data_error = r.derr;
  assign core_storage_int = r.sint;
  assign fetch_req_out = r.req;
  assign fetch_addr_out = r.addr;
  assign fetch_size_out = r.size;
  assign fetch_cacheable_out = r.cach;
  assign fetch_user_attr_out = r.uattr;
  assign fetch_priority_out = r.prio;
  assign fetch_abort_out = r.abort;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence acked_s;
    fetch_req_out && slave_addr_ack_in;
  endsequence
  sequence abort_s;
    fetch_abort_out && !slave_addr_ack_in;
  endsequence
  sequence pf_rise_s;
    $rose(fetch_req_out) && r.is_pf;
  endsequence

  req_drop_ack_a: assert property (acked_s |=> !fetch_req_out) // R24
    else $error("request still high after acknowledge");
  abort_drop_a: assert property (abort_s |=> !fetch_req_out && !fetch_abort_out) // R26
    else $error("aborted request did not drop");
  abort_with_req_a: assert property (fetch_abort_out |-> fetch_req_out) // R18
    else $error("abort without a pending request");
  size_code_a: assert property (fetch_req_out |-> (fetch_size_out == `IFPM_SIZE_4W)
    || (fetch_size_out == `IFPM_SIZE_8W)) // R16
    else $error("illegal size code");
  cach_size_a: assert property (fetch_req_out && fetch_cacheable_out
    |-> fetch_size_out == `IFPM_SIZE_8W) // R23
    else $error("cacheable fetch not eight words");
  pf_gap_a: assert property (pf_rise_s |-> $past(!fetch_req_out) && $past(r.cnt) == 2'h1) // R3
    else $error("prefetch raised too soon");
  pf_line_a: assert property (fetch_req_out && r.is_pf |-> fetch_addr_out
    == 30'((r.pf_base & `IFPM_LINE_MASK) + `IFPM_LINE_STEP)) // R1
    else $error("prefetch not the next line");
  pf_page_a: assert property (fetch_req_out && r.is_pf |-> fetch_addr_out[29:`IFPM_PAGE_LSB]
    == r.pf_base[29:`IFPM_PAGE_LSB]) // R5
    else $error("prefetch left the page");
  pf_cfg_a: assert property (pf_rise_s |-> $past(r.cfg[`IFPM_CFG_PIPE])
    && $past(r.cfg[`IFPM_CFG_NC8W]) && (r.cach ? $past(r.cfg[`IFPM_CFG_CPF])
    : $past(r.cfg[`IFPM_CFG_NCPF]))) // R4 R6 R7 R8
    else $error("prefetch against configuration");
  // a redirect against a pending prefetch is withdrawn through the abort cycle
  pf_single_a: assert property (fetch_req_out && r.is_pf && !fetch_abort_out // R9
    |-> r.cnt == 2'h1 && !r.redir)
    else $error("prefetch outside a single overlap");
  third_req_a: assert property ($rose(fetch_req_out) |-> r.cnt != 2'h2) // R25
    else $error("third request while two outstanding");
  guard_trap_a: assert property (core_storage_int |-> !fetch_req_out) // R14
    else $error("guarded prefetch reached the bus");
  addr_hold_a: assert property (fetch_req_out && !slave_addr_ack_in |=> $stable(fetch_addr_out)
    && $stable(fetch_size_out) && $stable(fetch_priority_out)) // R17
    else $error("request fields changed before acknowledge");
  data_ret_a: assert property (slave_rdata_ack_in && r.cnt != 2'h0 && !r.disc[r.head]
    && !core_redirect |=> core_data_valid && core_data == $past(slave_rdata_in)) // R20
    else $error("returned beat not forwarded");

  // core-side pulses, the abort pulse and the register port
  taken_empty_a: assert property (core_fetch_taken |-> fetch_req_out && r.cnt == 2'h0) // R25
    else $error("demand taken with lines outstanding");
  abort_pulse_a: assert property (fetch_abort_out |=> !fetch_abort_out) // R26
    else $error("abort held longer than one cycle");
  err_fwd_a: assert property (slave_error_in |=> core_data_error) // R22
    else $error("slave error not reported");
  trap_src_a: assert property (core_storage_int |-> $past(core_virt_mode & core_pf_guarded)) // R14
    else $error("trap without guarded virtual target");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside the read cycle");
endmodule : ifpm_fetch_master

/* File: ifpm_slave_model.sv */
`timescale 1ns/1ps
// behavioural local bus slave on the far side of the fetch port
module ifpm_slave_model
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [1:0] size,
  input wire logic abort,
  input wire logic slow,
  input wire logic wide,
  input wire logic err_inject,
  output logic addr_ack,
  output logic width,
  output logic rdata_ack,
  output logic [63:0] rdata,
  output logic [2:0] widx,
  output logic busy,
  output logic error
);
  int q[$]; // beats owed per accepted line, oldest first
  int wait_n; // cycles the pending request has waited
  int beat_n; // beats sent of the oldest line
  logic tog; // slow mode sends only every other cycle

  // address phase, then data beats strictly in acceptance order
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.delete();
      wait_n = 0;
      beat_n = 0;
      tog = 1'b0;
      addr_ack <= 1'b0;
      width <= 1'b0;
      rdata_ack <= 1'b0;
      rdata <= 64'h0;
      widx <= 3'h0;
      busy <= 1'b0;
      error <= 1'b0;
    end
    else
    begin
      // an ack seen together with the request makes the line owed
      if (req && addr_ack)
        q.push_back((size == 2'h2 ? 8 : 4) / (wide ? 2 : 1));
      // never ack a request that is being withdrawn
      if (req && !addr_ack && !abort && wait_n >= (slow ? 3 : 0))
        addr_ack <= 1'b1;
      else
        addr_ack <= 1'b0;
      width <= wide;
      wait_n = (req && !addr_ack) ? wait_n + 1 : 0;
      tog = ~tog;
      error <= 1'b0;
      if (q.size() != 0 && (!slow || tog))
      begin
        rdata_ack <= 1'b1;
        rdata <= {$urandom, $urandom};
        widx <= beat_n[2:0];
        error <= err_inject && beat_n == 0;
        beat_n = beat_n + 1;
        // oldest line finishes before the next one starts
        if (beat_n == q[0])
        begin
          void'(q.pop_front());
          beat_n = 0;
        end
      end
      else
      begin
        rdata_ack <= 1'b0;
        // released bus inverts data and index every idle cycle
        rdata <= ~rdata;
        widx <= ~widx;
      end
      busy <= q.size() != 0;
    end
  end
endmodule : ifpm_slave_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "ifpm_defs.svh"
// randomised bench for the fetch master against the slave model
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic core_fetch_req = 1'b0;
  logic [29:0] core_fetch_addr = 30'h0;
  logic core_fetch_cacheable = 1'b0;
  logic core_fetch_user_attr = 1'b0;
  logic [1:0] core_fetch_priority = 2'h0;
  logic core_redirect = 1'b0;
  logic core_virt_mode = 1'b0;
  logic core_pf_guarded = 1'b0;
  logic core_pf_in_cache = 1'b0;
  logic core_pf_in_fill = 1'b0;
  logic core_pf_from_ocm = 1'b0;
  logic [31:0] reg_rdata;
  logic core_fetch_taken, core_data_valid, core_data_error, core_storage_int;
  logic [63:0] core_data, slave_rdata_in, prev_rdata;
  logic [2:0] core_word_index, slave_word_index_in, prev_widx;
  logic fetch_req_out, fetch_cacheable_out, fetch_user_attr_out, fetch_abort_out;
  logic [29:0] fetch_addr_out;
  logic [1:0] fetch_size_out, fetch_priority_out;
  logic slave_addr_ack_in, slave_width_in, slave_rdata_ack_in, slave_busy_in, slave_error_in;
  logic slow = 1'b0, wide = 1'b1, err_inject = 1'b0; // slave behaviour per run
  int mismatches = 0, total_checks = 0;
  int cyc = 0, last_ack = -10, log_n, vld_n, sint_n, abort_n, err_n;
  logic [29:0] log_addr [2]; // accepted request addresses
  logic [1:0] log_size [2];
  logic [3:0] log_attr [2];
  logic abort_q = 1'b0, req_q = 1'b0;

  ifpm_fetch_master i_ifpm_fetch_master (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .core_fetch_req, .core_fetch_addr, .core_fetch_cacheable,
    .core_fetch_user_attr, .core_fetch_priority, .core_redirect, .core_virt_mode,
    .core_pf_guarded, .core_pf_in_cache, .core_pf_in_fill, .core_pf_from_ocm,
    .core_fetch_taken, .core_data, .core_data_valid, .core_word_index, .core_data_error,
    .core_storage_int, .fetch_req_out, .fetch_addr_out, .fetch_size_out,
    .fetch_cacheable_out, .fetch_user_attr_out, .fetch_priority_out, .fetch_abort_out,
    .slave_addr_ack_in, .slave_width_in, .slave_rdata_ack_in, .slave_rdata_in,
    .slave_word_index_in, .slave_busy_in, .slave_error_in);

  ifpm_slave_model i_ifpm_slave_model (.ref_clk, .rst_n, .req(fetch_req_out),
    .size(fetch_size_out), .abort(fetch_abort_out), .slow, .wide, .err_inject,
    .addr_ack(slave_addr_ack_in), .width(slave_width_in), .rdata_ack(slave_rdata_ack_in),
    .rdata(slave_rdata_in), .widx(slave_word_index_in), .busy(slave_busy_in),
    .error(slave_error_in));

  // free-running core clock
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // port monitor: logs accepted requests, checks spacing and beats
  always @(posedge ref_clk)
  begin
    cyc++;
    if (fetch_req_out && !req_q)
      check("req_gap", 64'(cyc - last_ack >= 2), 64'h1);
    if (abort_q)
      check("abort_drop", 64'(fetch_req_out), 64'h0);
    if (fetch_abort_out)
      abort_n++;
    abort_q = fetch_abort_out && fetch_req_out;
    req_q = fetch_req_out;
    if (fetch_req_out && slave_addr_ack_in)
    begin
      if (log_n < 2)
      begin
        log_addr[log_n] = fetch_addr_out;
        log_size[log_n] = fetch_size_out;
        log_attr[log_n] = {fetch_cacheable_out, fetch_user_attr_out, fetch_priority_out};
      end
      log_n++;
      last_ack = cyc;
    end
    if (core_data_valid)
    begin
      vld_n++;
      check("data", core_data, prev_rdata);
      check("index", 64'(core_word_index), 64'(prev_widx));
    end
    if (slave_rdata_ack_in)
    begin
      prev_rdata = slave_rdata_in;
      prev_widx = slave_word_index_in;
    end
    sint_n += core_storage_int;
    err_n += core_data_error;
  end

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(name, 64'(reg_rdata), 64'(exp));
  endtask : reg_check

  // prefetch qualification for the demand now on the core inputs
  function automatic logic pf_ok(input logic [3:0] cfg);
    logic [29:0] nxt;
    nxt = (core_fetch_addr & `IFPM_LINE_MASK) + `IFPM_LINE_STEP;
    return cfg[3] && cfg[0]
      && (core_fetch_cacheable ? cfg[2] && !core_pf_in_cache : cfg[1])
      && nxt[29:8] == core_fetch_addr[29:8]
      && !core_pf_in_fill && !core_pf_from_ocm;
  endfunction : pf_ok

  // one demand fetch, optionally redirected while still unacknowledged
  task automatic run_fetch(input logic [3:0] cfg, input logic redir);
    logic pf;
    logic [1:0] sz;
    int n;
    int idle;
    @(negedge ref_clk);
    log_n = 0;
    vld_n = 0;
    sint_n = 0;
    abort_n = 0;
    err_n = 0;
    @(posedge ref_clk);
    core_fetch_req <= 1'b1;
    pf = pf_ok(cfg) && !(core_virt_mode && core_pf_guarded) && !redir;
    sz = (core_fetch_cacheable || cfg[0]) ? `IFPM_SIZE_8W : `IFPM_SIZE_4W;
    n = 0;
    do @(negedge ref_clk); while (core_fetch_taken !== 1'b1 && ++n < 50);
    check("taken", 64'(core_fetch_taken), 64'h1);
    @(posedge ref_clk);
    core_fetch_req <= 1'b0;
    core_redirect <= redir;
    @(posedge ref_clk);
    core_redirect <= 1'b0;
    idle = 0;
    for (n = 0; idle < 4 && n < 300; n++)
    begin
      @(negedge ref_clk);
      idle = (slave_busy_in || fetch_req_out) ? 0 : idle + 1;
    end
    check("idle", 64'(idle >= 4), 64'h1);
    if (redir)
    begin
      check("abort_n", 64'(abort_n), 64'h1);
      check("req_n", 64'(log_n), 64'h0);
      check("valid_n", 64'(vld_n), 64'h0);
    end
    else
    begin
      check("req_n", 64'(log_n), 64'(1 + pf));
      check("addr", 64'(log_addr[0]), 64'(core_fetch_addr));
      check("size", 64'(log_size[0]), 64'(sz));
      check("attrs", 64'(log_attr[0]), 64'({core_fetch_cacheable,
        core_fetch_user_attr, core_fetch_priority}));
      check("trap", 64'(sint_n), 64'(pf_ok(cfg) && core_virt_mode && core_pf_guarded));
      check("valid_n", 64'(vld_n), 64'(((sz == `IFPM_SIZE_8W ? 8 : 4) + pf * 8) / (wide ? 2 : 1)));
      check("err_n", 64'(err_n), 64'(err_inject * (1 + pf)));
      if (pf)
      begin
        check("pf_addr", 64'(log_addr[1]), 64'((core_fetch_addr & `IFPM_LINE_MASK)
          + `IFPM_LINE_STEP));
        check("pf_size", 64'(log_size[1]), 64'(`IFPM_SIZE_8W));
      end
    end
    $display("test done: fetch %h prefetch %0d redirect %0d", core_fetch_addr, pf, redir);
  endtask : run_fetch

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // watchdog: far beyond the few thousand cycles the tests need
  initial
  begin
    #500000;
    mismatches++;
    close_out();
  end

  // main sequence
  initial
  begin
    logic [3:0] cfg;
    logic [31:0] r;
    logic [31:0] a;
    void'($urandom(32'hA1E5AA41));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_check(`IFPM_REG_CFG, 32'h0, "cfg_reset");
    reg_check(`IFPM_REG_STAT, 32'h0, "stat_reset");
    reg_write(8'h08, 32'hFFFFFFFF);
    reg_check(8'h08, 32'h0, "unmapped");
    reg_check(`IFPM_REG_CFG, 32'h0, "cfg_kept");
    for (int t = 0; t < 60; t++)
    begin
      r = $urandom;
      a = $urandom;
      // enables mostly set so that prefetches really happen
      cfg = {r[0] | r[1], r[2] | r[3], r[4] | r[5], r[6] | r[7]};
      reg_write(`IFPM_REG_CFG, 32'(cfg));
      reg_check(`IFPM_REG_CFG, 32'(cfg), "cfg");
      @(posedge ref_clk);
      // every fourth demand sits in the last line of its page
      core_fetch_addr <= (t % 4 == 0) ? {a[29:8], 5'h1F, a[2:0]} : a[29:0];
      core_fetch_cacheable <= r[8];
      core_fetch_user_attr <= r[9];
      core_fetch_priority <= r[11:10];
      core_virt_mode <= r[12];
      core_pf_guarded <= r[13] & r[14];
      core_pf_in_cache <= r[15] & r[16];
      core_pf_in_fill <= r[17] & r[18];
      core_pf_from_ocm <= r[19] & r[20];
      slow <= r[21];
      wide <= r[22];
      err_inject <= (t % 10 == 3);
      run_fetch(cfg, 1'b0);
    end
    reg_write(`IFPM_REG_STAT, 32'h00000060);
    reg_check(`IFPM_REG_STAT, 32'h0, "stat_clear");
    // slave error on a plain demand leaves the sticky flag
    @(posedge ref_clk);
    core_virt_mode <= 1'b0;
    err_inject <= 1'b1;
    run_fetch(cfg, 1'b0);
    reg_check(`IFPM_REG_STAT, 32'h00000020, "err_sticky");
    // slow slave: a redirect must withdraw the unacknowledged request
    @(posedge ref_clk);
    err_inject <= 1'b0;
    slow <= 1'b1;
    run_fetch(cfg, 1'b1);
    close_out();
  end
endmodule : testbench
